/* File: verilog/sws_pkg.sv */
// Purpose: Constants for the switch status register block.
// Assumes: Registers are reached over APB with 32-bit data.
// Notes:   Offsets are byte addresses; every field position lives here.
//
// Overview of operation
// RULE1: Mode straps read at bits 3:0.
// RULE2: Board keeps straps static after reset release.
// RULE3: Downstream common-clock strap latched at bit 5.
// RULE4: Upstream common-clock strap latched at bit 6.
// RULE5: SMBus slow-mode strap latched at bit 7.
// RULE6: Reference-clock mode strap latched at bit 8.
// RULE7: Reset-halt strap latched at bit 9.
// RULE8: Four merge straps latched at bits 15:12.
// RULE9: Two-bit base spec mode at bits 11:10.
// RULE10: Mode field writable only while unlocked.
// RULE11: Upstream lock owner read at bits 22:20.
// RULE12: Marker 31:28 cleared by fundamental reset only.
// RULE13: Reserved bits read zero; read-only writes ignored.
package sws_pkg;

    localparam logic [11:0] SWS_STATUS_OFFSET = 12'h400;
    localparam int          SWS_DATA_W        = 32;

    localparam int SWS_MODE_LSB   = 0;
    localparam int SWS_MODE_W     = 4;
    localparam int SWS_CCDS_BIT   = 5;
    localparam int SWS_CCUS_BIT   = 6;
    localparam int SWS_SMBS_BIT   = 7;
    localparam int SWS_REFCK_BIT  = 8;
    localparam int SWS_HALT_BIT   = 9;
    localparam int SWS_BSM_LSB    = 10;
    localparam int SWS_BSM_W      = 2;
    localparam int SWS_MERGE_LSB  = 12;
    localparam int SWS_MERGE_W    = 4;
    localparam int SWS_LOCK_LSB   = 20;
    localparam int SWS_LOCK_W     = 3;
    localparam int SWS_MARK_LSB   = 28;
    localparam int SWS_MARK_W     = 4;

    localparam logic [31:0] SWS_RSV_MASK = 32'h0F8F_0010;

    localparam logic [3:0]  SWS_MODE_NORMAL    = 4'h0;
    localparam logic [3:0]  SWS_MODE_EEPROM    = 4'h1;
    localparam logic [1:0]  SWS_BSM_V1P1       = 2'h1;
    localparam logic [1:0]  SWS_BSM_RESET      = 2'h1;
    localparam logic [3:0]  SWS_MARK_RESET     = 4'h0;
    localparam logic [3:0]  SWS_MERGE_RESET    = 4'h0;
    localparam logic [3:0]  SWS_MODE_RESET     = 4'h0;
    localparam logic [2:0]  SWS_LOCK_UNLOCKED  = 3'h0;

    localparam int SWS_STRAP_W    = 13;
    localparam int SWS_SYNC_W     = SWS_STRAP_W + 1;
    localparam logic [SWS_SYNC_W-1:0] SWS_SYNC_RESET = 14'h0000;

endpackage

/* File: verilog/sws_sync3.sv */
// Purpose: Three-stage synchroniser with an agreement filter per bit.
// Assumes: Inputs are asynchronous pins.
// Notes:   The output only moves once stages two and three agree.
`timescale 1ns/1ps
module sws_sync3 #(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_nxt;

    initial begin
        if (WIDTH < 1) $error("sws_sync3: WIDTH must be at least 1");
    end

    // A bit that still disagrees between stages keeps its old value.
    assign level_nxt = (s2_r & s3_r) | (level_out & (s2_r ^ s3_r));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r      <= RST_VAL;
            s2_r      <= RST_VAL;
            s3_r      <= RST_VAL;
            level_out <= RST_VAL;
        end else begin
            s1_r      <= pin_in;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            level_out <= level_nxt;
        end
    end
endmodule // sws_sync3

/* File: verilog/sws_apb_port.sv */
// Purpose: APB slave front end: decode, strobes and error answer.
// Assumes: One register word at a fixed byte offset.
// Notes:   Zero wait states; the error flag is set up in the setup cycle.
`timescale 1ns/1ps
module sws_apb_port #(
    parameter int          ADDR_W = 12,
    parameter logic [ADDR_W-1:0] OFFSET = '0
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   setup_rd,
    output logic                   commit_wr,
    output logic                   hit
);
    logic setup;

    initial begin
        if (ADDR_W < 11) $error("sws_apb_port: ADDR_W too small for offset");
    end

    assign hit       = (paddr[ADDR_W-1:2] == OFFSET[ADDR_W-1:2]);
    assign setup     = psel & ~penable;
    assign setup_rd  = setup & ~pwrite;
    assign pready    = 1'b1;
    assign commit_wr = psel & penable & pwrite & hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= ~hit;
        end
    end
endmodule // sws_apb_port

/* File: verilog/sws_status.sv */
// Purpose: Switch status register: latched straps, mode, lock owner, marker.
// Assumes: Straps and the fundamental reset pin are asynchronous to pclk.
// Notes:   Lock owner, unlock control and hot reset come from pclk logic.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module sws_status
    import sws_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    fundamental_reset_input_n,
    input  wire logic                    hot_reset,
    input  wire logic [3:0]              operating_mode_straps,
    input  wire logic                    common_clock_downstream,
    input  wire logic                    common_clock_upstream,
    input  wire logic                    master_smbus_slow_select,
    input  wire logic                    ref_clock_mode_select,
    input  wire logic                    hold_in_reset_strap,
    input  wire logic                    merge_ports_zero_one,
    input  wire logic                    merge_ports_two_three,
    input  wire logic                    merge_ports_four_five,
    input  wire logic                    merge_ports_six_seven,
    input  wire logic                    write_unlock_control,
    input  wire logic [2:0]              upstream_lock_state,
    output logic      [3:0]              operating_mode,
    output logic      [1:0]              base_spec_mode,
    output logic                         fundamental_reset_active
);
    import sws_pkg::*;

    initial begin
        if (ADDR_W < 11 || ADDR_W > 32) $error("sws_status: ADDR_W out of range");
    end

    logic [SWS_SYNC_W-1:0]   pins_raw;
    logic [SWS_SYNC_W-1:0]   pins_sync;
    logic                    fund_active;
    logic                    setup_rd;
    logic                    commit_wr;
    logic                    hit;

    logic [SWS_MODE_W-1:0]   mode_r;
    logic                    ccds_r;
    logic                    ccus_r;
    logic                    smbs_r;
    logic                    refck_r;
    logic                    halt_r;
    logic [SWS_MERGE_W-1:0]  merge_r;
    logic [SWS_BSM_W-1:0]    bsm_r;
    logic [SWS_BSM_W-1:0]    bsm_nxt;
    logic [SWS_MARK_W-1:0]   mark_r;
    logic [SWS_MARK_W-1:0]   mark_nxt;
    logic [31:0]             prdata_r;
    logic [31:0]             status_word;
    logic [31:0]             rd_nxt;
    logic                    bsm_wr_ok;

    // Packs the visible fields; every bit not named stays zero.
    function automatic logic [31:0] pack_status(
        input logic [3:0] mode,
        input logic       ccds,
        input logic       ccus,
        input logic       smbs,
        input logic       refck,
        input logic       halt,
        input logic [1:0] bsm,
        input logic [3:0] merge,
        input logic [2:0] lock,
        input logic [3:0] mark
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SWS_MODE_LSB +: SWS_MODE_W]   = mode;
        w[SWS_CCDS_BIT]                 = ccds;
        w[SWS_CCUS_BIT]                 = ccus;
        w[SWS_SMBS_BIT]                 = smbs;
        w[SWS_REFCK_BIT]                = refck;
        w[SWS_HALT_BIT]                 = halt;
        w[SWS_BSM_LSB +: SWS_BSM_W]     = bsm;
        w[SWS_MERGE_LSB +: SWS_MERGE_W] = merge;
        w[SWS_LOCK_LSB +: SWS_LOCK_W]   = lock;
        w[SWS_MARK_LSB +: SWS_MARK_W]   = mark;
        return w;
    endfunction

    // Merge straps are packed with pair 0/1 in the lowest bit.
    assign pins_raw = {fundamental_reset_input_n,
                       merge_ports_six_seven, merge_ports_four_five,
                       merge_ports_two_three, merge_ports_zero_one,
                       hold_in_reset_strap, ref_clock_mode_select,
                       master_smbus_slow_select, common_clock_upstream,
                       common_clock_downstream, operating_mode_straps};

    sws_sync3 #(
        .WIDTH   (SWS_SYNC_W),
        .RST_VAL (SWS_SYNC_RESET)
    ) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (pins_raw),
        .level_out (pins_sync)
    );

    sws_apb_port #(
        .ADDR_W (ADDR_W),
        .OFFSET (ADDR_W'(SWS_STATUS_OFFSET))
    ) u_apb (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pready    (pready),
        .pslverr   (pslverr),
        .setup_rd  (setup_rd),
        .commit_wr (commit_wr),
        .hit       (hit)
    );

    // The sync resets low, so the block counts as in fundamental reset until
    // the pin has been seen high; straps are then caught on every edge.
    assign fund_active = ~pins_sync[SWS_SYNC_W-1];

    // Straps are sampled every cycle of fundamental reset and frozen after.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r  <= SWS_MODE_RESET;
            ccds_r  <= 1'b0;
            ccus_r  <= 1'b0;
            smbs_r  <= 1'b0;
            refck_r <= 1'b0;
            halt_r  <= 1'b0;
            merge_r <= SWS_MERGE_RESET;
        end else if (fund_active) begin
            mode_r  <= pins_sync[3:0];  // RULE1
            ccds_r  <= pins_sync[4];    // RULE3
            ccus_r  <= pins_sync[5];    // RULE4
            smbs_r  <= pins_sync[6];    // RULE5
            refck_r <= pins_sync[7];    // RULE6
            halt_r  <= pins_sync[8];    // RULE7
            merge_r <= pins_sync[12:9]; // RULE8
        end
    end

    // The mode field follows writes only while the unlock control is set.
    assign bsm_wr_ok = commit_wr & write_unlock_control; // RULE10
    assign bsm_nxt   = fund_active ? SWS_BSM_RESET :
                       bsm_wr_ok   ? pwdata[SWS_BSM_LSB +: SWS_BSM_W] : bsm_r; // RULE9

    // Hot reset is deliberately absent here so the marker survives it.
    assign mark_nxt  = fund_active ? SWS_MARK_RESET :
                       commit_wr   ? pwdata[SWS_MARK_LSB +: SWS_MARK_W] : mark_r; // RULE12

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsm_r  <= SWS_BSM_RESET;
            mark_r <= SWS_MARK_RESET;
        end else begin
            bsm_r  <= bsm_nxt;
            mark_r <= mark_nxt;
        end
    end

    assign status_word = pack_status(mode_r, ccds_r, ccus_r, smbs_r, refck_r, halt_r,
                                     bsm_r, merge_r, upstream_lock_state, mark_r); // RULE11
    assign rd_nxt      = hit ? status_word : 32'h0000_0000; // RULE13

    // Read data is set up in the setup cycle so it comes from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_r <= rd_nxt;
        end
    end

    assign prdata                   = prdata_r;
    assign operating_mode           = mode_r;
    assign base_spec_mode           = bsm_r;
    assign fundamental_reset_active = fund_active;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd_setup;
        setup_rd && hit;
    endsequence

    sequence s_quiet;
        !fund_active && !commit_wr;
    endsequence

    property p_mode_read;
        s_rd_setup |=> prdata[3:0] == $past(mode_r);
    endproperty
    a_mode_read: assert property (p_mode_read) // RULE1
        else $error("Mode straps missing from read data.");

    property p_ccds_cap;
        fund_active |=> ccds_r == $past(pins_sync[4]);
    endproperty
    a_ccds_cap: assert property (p_ccds_cap) // RULE3
        else $error("Downstream clock strap not captured.");

    property p_ccus_read;
        s_rd_setup |=> prdata[SWS_CCUS_BIT] == $past(ccus_r);
    endproperty
    a_ccus_read: assert property (p_ccus_read) // RULE4
        else $error("Upstream clock strap at wrong bit.");

    property p_smbs_cap;
        fund_active ##1 !fund_active |-> smbs_r == $past(pins_sync[6]);
    endproperty
    a_smbs_cap: assert property (p_smbs_cap) // RULE5
        else $error("SMBus slow strap not caught at release.");

    property p_refck_hold;
        !fund_active |=> $stable(refck_r);
    endproperty
    a_refck_hold: assert property (p_refck_hold) // RULE6
        else $error("Reference clock strap moved after reset.");

    property p_halt_read;
        s_rd_setup |=> prdata[SWS_HALT_BIT] == $past(halt_r);
    endproperty
    a_halt_read: assert property (p_halt_read) // RULE7
        else $error("Reset halt strap at wrong bit.");

    property p_merge_hold;
        (!fund_active)[*2] |-> $stable(merge_r) && $stable(mode_r);
    endproperty
    a_merge_hold: assert property (p_merge_hold) // RULE8
        else $error("Merge or mode straps moved after reset.");

    property p_bsm_fund;
        fund_active |=> bsm_r == SWS_BSM_V1P1;
    endproperty
    a_bsm_fund: assert property (p_bsm_fund) // RULE9
        else $error("Base spec mode not at its reset value.");

    property p_bsm_locked;
        (!fund_active && !write_unlock_control) |=> $stable(bsm_r);
    endproperty
    a_bsm_locked: assert property (p_bsm_locked) // RULE10
        else $error("Mode field changed while locked.");

    property p_bsm_write;
        (commit_wr && write_unlock_control && !fund_active)
            |=> bsm_r == $past(pwdata[11:10]);
    endproperty
    a_bsm_write: assert property (p_bsm_write) // RULE10
        else $error("Unlocked write to mode field lost.");

    property p_lock_read;
        s_rd_setup |=> prdata[22:20] == $past(upstream_lock_state);
    endproperty
    a_lock_read: assert property (p_lock_read) // RULE11
        else $error("Lock owner missing from read data.");

    property p_mark_hot;
        (s_quiet and hot_reset) |=> $stable(mark_r);
    endproperty
    a_mark_hot: assert property (p_mark_hot) // RULE12
        else $error("Marker disturbed by hot reset.");

    property p_mark_fund;
        fund_active |=> mark_r == SWS_MARK_RESET ##1 (!fund_active || mark_r == 4'h0);
    endproperty
    a_mark_fund: assert property (p_mark_fund) // RULE12
        else $error("Marker not cleared by fundamental reset.");

    property p_rsv_zero;
        (psel && penable && !pwrite) |-> (prdata & SWS_RSV_MASK) == 32'h0000_0000;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) // RULE13
        else $error("Reserved bit read as one.");

    property p_unmapped;
        (setup_rd && !hit) |=> prdata == 32'h0000_0000 && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) // RULE13
        else $error("Unmapped read did not answer zero with error.");

    property p_ccds_read;
        s_rd_setup |=> prdata[SWS_CCDS_BIT] == $past(ccds_r);
    endproperty
    a_ccds_read: assert property (p_ccds_read) // RULE3
        else $error("Downstream clock strap at wrong bit.");

    property p_mark_write;
        (commit_wr && !fund_active) |=> mark_r == $past(pwdata[31:28]);
    endproperty
    a_mark_write: assert property (p_mark_write) // RULE12
        else $error("Marker write lost.");

    // A write that hits the word must leave the merge, reset-halt and downstream clock straps alone.
    property p_ro_write;
        (commit_wr && !fund_active) |=> $stable(merge_r) && $stable(halt_r) && $stable(ccds_r);
    endproperty
    a_ro_write: assert property (p_ro_write) // RULE13
        else $error("Read-only strap changed by a write.");

endmodule // sws_status

/* File: sim/sws_status_tb.sv */
// Purpose: Self-checking bench for the switch status register over APB.
// Assumes: Zero-wait APB slave; straps stay steady outside fundamental reset.
// Notes:   An int field model predicts every read of the status word.
`timescale 1ns/1ps
module sws_status_tb;
    import sws_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fundamental_reset_input_n;
    logic        hot_reset;
    logic [3:0]  operating_mode_straps;
    logic        common_clock_downstream;
    logic        common_clock_upstream;
    logic        master_smbus_slow_select;
    logic        ref_clock_mode_select;
    logic        hold_in_reset_strap;
    logic        merge_ports_zero_one;
    logic        merge_ports_two_three;
    logic        merge_ports_four_five;
    logic        merge_ports_six_seven;
    logic        write_unlock_control;
    logic [2:0]  upstream_lock_state;
    logic [3:0]  operating_mode;
    logic [1:0]  base_spec_mode;
    logic        fundamental_reset_active;
    int          failures;
    int          comparisons;
    int          seed;
    int          m_mode;
    int          m_flags;
    int          m_bsm;
    int          m_merge;
    int          m_lock;
    int          m_mark;
    int          lock_q[$];

    always #10 pclk = ~pclk;

    sws_status #(.ADDR_W(12)) DUT (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .prdata                    (prdata),
        .pready                    (pready),
        .pslverr                   (pslverr),
        .fundamental_reset_input_n (fundamental_reset_input_n),
        .hot_reset                 (hot_reset),
        .operating_mode_straps     (operating_mode_straps),
        .common_clock_downstream   (common_clock_downstream),
        .common_clock_upstream     (common_clock_upstream),
        .master_smbus_slow_select  (master_smbus_slow_select),
        .ref_clock_mode_select     (ref_clock_mode_select),
        .hold_in_reset_strap       (hold_in_reset_strap),
        .merge_ports_zero_one      (merge_ports_zero_one),
        .merge_ports_two_three     (merge_ports_two_three),
        .merge_ports_four_five     (merge_ports_four_five),
        .merge_ports_six_seven     (merge_ports_six_seven),
        .write_unlock_control      (write_unlock_control),
        .upstream_lock_state       (upstream_lock_state),
        .operating_mode            (operating_mode),
        .base_spec_mode            (base_spec_mode),
        .fundamental_reset_active  (fundamental_reset_active)
    );

    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic check_flag(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    function automatic logic [31:0] exp_word();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SWS_MODE_LSB +: SWS_MODE_W]   = m_mode[3:0];
        w[SWS_CCDS_BIT +: 5]            = m_flags[4:0];
        w[SWS_BSM_LSB +: SWS_BSM_W]     = m_bsm[1:0];
        w[SWS_MERGE_LSB +: SWS_MERGE_W] = m_merge[3:0];
        w[SWS_LOCK_LSB +: SWS_LOCK_W]   = m_lock[2:0];
        w[SWS_MARK_LSB +: SWS_MARK_W]   = m_mark[3:0];
        return w;
    endfunction

    // The request is held until pready is seen high; the bench never assumes a latency.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            $display("unexpected pready: expected 1, seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic read_check();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, SWS_STATUS_OFFSET, 32'h0000_0000, rd, err);
        check_word("status word", exp_word(), rd);
        check_flag("status error", 1'b0, err);
        check_word("mode output", 32'(m_mode[3:0]), 32'(operating_mode));
        check_word("spec mode output", 32'(m_bsm[1:0]), 32'(base_spec_mode));
    endtask

    // Straps change only together with the pin going low, so they are steady for
    // eight cycles before release, twice what the synchroniser needs.
    task automatic fund_reset(input int mode_pick);
        logic [12:0] v;
        int          n;
        v = 13'($random(seed));
        if (mode_pick >= 0) v[3:0] = 4'(mode_pick);
        @(posedge pclk);
        fundamental_reset_input_n <= 1'b0;
        operating_mode_straps     <= v[3:0];
        {hold_in_reset_strap, ref_clock_mode_select, master_smbus_slow_select,
         common_clock_upstream, common_clock_downstream} <= v[8:4];
        {merge_ports_six_seven, merge_ports_four_five, merge_ports_two_three,
         merge_ports_zero_one} <= v[12:9];
        repeat (6) @(posedge pclk);
        check_flag("reset seen", 1'b1, fundamental_reset_active);
        repeat (2) @(posedge pclk);
        fundamental_reset_input_n <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (fundamental_reset_active !== 1'b0 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("unexpected reset release: expected 0, seen %b", fundamental_reset_active);
        end
        m_mode  = v[3:0];
        m_flags = v[8:4];
        m_merge = v[12:9];
        m_bsm   = 1;
        m_mark  = 0;
    endtask

    initial begin
        logic [31:0] d;
        logic [31:0] rd;
        logic        err;
        logic [11:0] bad_addr [3];
        bad_addr = '{12'h000, 12'h404, 12'hFFC};
        seed = 32'hceaa;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fundamental_reset_input_n = 1'b0;
        hot_reset = 1'b0;
        operating_mode_straps = 4'h0;
        {common_clock_downstream, common_clock_upstream, master_smbus_slow_select} = 3'h0;
        {ref_clock_mode_select, hold_in_reset_strap} = 2'h0;
        {merge_ports_zero_one, merge_ports_two_three} = 2'h0;
        {merge_ports_four_five, merge_ports_six_seven} = 2'h0;
        write_unlock_control = 1'b0;
        upstream_lock_state = 3'h0;
        failures = 0;
        comparisons = 0;
        m_lock = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        fund_reset(0);
        read_check();
        $display("test straps done");
        for (int i = 0; i < 8; i++) lock_q.push_back(i);
        while (lock_q.size() > 0) begin
            m_lock = lock_q.pop_front();
            upstream_lock_state <= 3'(m_lock);
            read_check();
        end
        $display("test lock state done");
        for (int u = 0; u < 2; u++) begin
            write_unlock_control <= u[0];
            for (int i = 0; i < 4; i++) begin
                d = $random(seed);
                d[11:10] = 2'(i);
                apb(1'b1, SWS_STATUS_OFFSET, d, rd, err);
                check_flag("write error", 1'b0, err);
                m_mark = d[31:28];
                if (u == 1) m_bsm = i;
                read_check();
            end
        end
        write_unlock_control <= 1'b0;
        $display("test writes done");
        hot_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        hot_reset <= 1'b0;
        read_check();
        $display("test hot reset done");
        foreach (bad_addr[k]) begin
            apb(1'b1, bad_addr[k], 32'hFFFF_FFFF, rd, err);
            check_flag("unmapped write error", 1'b1, err);
            apb(1'b0, bad_addr[k], 32'h0000_0000, rd, err);
            check_word("unmapped read", 32'h0000_0000, rd);
            check_flag("unmapped read error", 1'b1, err);
            read_check();
        end
        $display("test unmapped done");
        for (int i = 0; i < 4; i++) begin
            write_unlock_control <= 1'b1;
            d = $random(seed) | 32'h8000_0800;
            apb(1'b1, SWS_STATUS_OFFSET, d, rd, err);
            m_mark = d[31:28];
            m_bsm = d[11:10];
            read_check();
            fund_reset(i == 0 ? 1 : -1);
            read_check();
        end
        $display("test repeated fundamental reset done");
        report_and_stop();
    end

    // The full sequence needs well under a thousand cycles; this leaves wide margin.
    initial begin
        repeat (4000) @(posedge pclk);
        failures++;
        $display("unexpected watchdog: expected finish, seen timeout");
        report_and_stop();
    end

endmodule // sws_status_tb
